//--- asbi_map.svh
// Functional notes
// - host keeps a select or the strobe inactive while the address moves.
// - a write starts at the last of the select and strobe activating edges.
// - a write ends at the first select or strobe deactivating edge.
// - host avoids driving data while the device outputs are still on.
// - host holds write data set up before and held after the ending edge.
`ifndef ASBI_MAP_SVH
`define ASBI_MAP_SVH

// widths and lane bit positions
`define ASBI_ADDR_W 17
`define ASBI_DATA_W 16
`define ASBI_CNT_W 8
`define ASBI_LANE_HI 15
`define ASBI_LANE_HI_LO 8
`define ASBI_LANE_LO_HI 7
`define ASBI_LANE_LO 0

// clock rate in megahertz, timing figures in nanoseconds, synchroniser delay in cycles
`define ASBI_CLK_MHZ 10
`define ASBI_T_ACC_NS 120
`define ASBI_T_AS_NS 10
`define ASBI_T_WP_NS 100
`define ASBI_T_DH_NS 10
`define ASBI_SYNC_CYC 3

// least times rounded up to whole cycles, at least one
`define ASBI_CEIL_CYC(ns) \
  (((((ns) * `ASBI_CLK_MHZ) + 999) / 1000) < 1 ? 1 : \
   ((((ns) * `ASBI_CLK_MHZ) + 999) / 1000))
`define ASBI_ACC_CYC `ASBI_CEIL_CYC(`ASBI_T_ACC_NS)
`define ASBI_RD_CYC (`ASBI_ACC_CYC + `ASBI_SYNC_CYC)
`define ASBI_AS_CYC `ASBI_CEIL_CYC(`ASBI_T_AS_NS)
`define ASBI_WP_CYC `ASBI_CEIL_CYC(`ASBI_T_WP_NS)
`define ASBI_DH_CYC `ASBI_CEIL_CYC(`ASBI_T_DH_NS)

// reset and idle values, and the count of one that ends a wait
`define ASBI_ADDR_RST 17'h00000
`define ASBI_DATA_RST 16'h0000
`define ASBI_CNT_ONE 8'h01
`define ASBI_CNT_RST 8'h00

`endif

//--- asbi_pkg.sv
`include "asbi_map.svh"

package asbi_pkg;
  typedef logic [`ASBI_ADDR_W-1:0] asbi_addr_t;
  typedef logic [`ASBI_DATA_W-1:0] asbi_data_t;
  typedef logic [`ASBI_CNT_W-1:0] asbi_cnt_t;

  typedef enum logic [2:0] {
    ASBI_IDLE,
    ASBI_RD,
    ASBI_WR_SETUP,
    ASBI_WR_PULSE,
    ASBI_WR_HOLD
  } asbi_state_e;
endpackage

//--- asbi_host_ctrl.sv
`timescale 1ns/100ps
`include "asbi_map.svh"

module asbi_host_ctrl
  import asbi_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // user request side
  input wire logic req,
  input wire logic req_write,
  input wire asbi_addr_t req_addr,
  input wire asbi_data_t req_wdata,
  input wire logic req_upper,
  input wire logic req_lower,
  output logic busy,
  output logic rd_valid,
  output asbi_data_t rd_data,
  // memory pins
  output asbi_addr_t mem_addr,
  output logic chip_select_active_low,
  output logic chip_select_active_high,
  output logic write_strobe_n,
  output logic output_drive_enable_n,
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  // data pins, split three ways
  input wire asbi_data_t dq_in,
  output asbi_data_t dq_out,
  output logic dq_oe_n
);

  // sequencer state and its wait counter
  asbi_state_e state;
  asbi_state_e next_state;
  asbi_cnt_t cnt;
  asbi_cnt_t next_cnt;

  // data pins after the first and second flip-flop
  asbi_data_t dq_meta;
  asbi_data_t dq_sync;

  // next values of every registered output
  logic next_busy;
  logic next_rd_valid;
  asbi_data_t next_rd_data;
  asbi_addr_t next_mem_addr;
  logic next_cs_l;
  logic next_cs_h;
  logic next_ws_n;
  logic next_oe_n;
  logic next_ub_n;
  logic next_lb_n;
  asbi_data_t next_dq_out;
  logic next_dq_oe_n;

  // two-stage synchroniser on the data pins
  // only dq_sync is read by the sequencer, never dq_meta
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dq_meta <= `ASBI_DATA_RST;
      dq_sync <= `ASBI_DATA_RST;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  // next-state and pin values for the access sequencer
  always_comb begin
    // everything but rd_valid holds unless a state below moves it; rd_valid defaults low
    next_state = state;
    next_cnt = cnt;
    next_busy = busy;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_mem_addr = mem_addr;
    next_cs_l = chip_select_active_low;
    next_cs_h = chip_select_active_high;
    next_ws_n = write_strobe_n;
    next_oe_n = output_drive_enable_n;
    next_ub_n = upper_lane_enable_n;
    next_lb_n = lower_lane_enable_n;
    next_dq_out = dq_out;
    next_dq_oe_n = dq_oe_n;
    case (state)
      ASBI_IDLE: begin
        // requests are taken only here, so one made while busy is lost
        if (req) begin
          // address moves while the strobe is still high
          next_mem_addr = req_addr;
          next_cs_l = 1'b0;
          next_cs_h = 1'b1;
          next_ws_n = 1'b1;
          next_ub_n = ~req_upper;
          next_lb_n = ~req_lower;
          next_busy = 1'b1;
          if (req_write) begin
            // drive data only with the memory outputs kept off
            next_oe_n = 1'b1;
            next_dq_out = req_wdata;
            next_dq_oe_n = 1'b0;
            next_cnt = asbi_cnt_t'(`ASBI_AS_CYC);
            next_state = ASBI_WR_SETUP;
          end else begin
            // read: strobe high, drive enable low, selects on
            next_oe_n = 1'b0;
            next_dq_oe_n = 1'b1;
            // all controls change with the address, so the wait is timed
            // from the access time plus the synchroniser latency
            next_cnt = asbi_cnt_t'(`ASBI_RD_CYC);
            next_state = ASBI_RD;
          end
        end
      end
      ASBI_RD: begin
        if (cnt == `ASBI_CNT_ONE) begin
          // sample only after the access time has passed
          next_rd_data = dq_sync;
          next_rd_valid = 1'b1;
          next_busy = 1'b0;
          // release the selects: standby until the next request
          next_cs_l = 1'b1;
          next_cs_h = 1'b0;
          next_oe_n = 1'b1;
          next_ub_n = 1'b1;
          next_lb_n = 1'b1;
          next_state = ASBI_IDLE;
        end else begin
          // access time not yet covered: keep counting
          next_cnt = cnt - `ASBI_CNT_ONE;
        end
      end
      ASBI_WR_SETUP: begin
        if (cnt == `ASBI_CNT_ONE) begin
          // strobe fall is the last activating edge: write begins
          next_ws_n = 1'b0;
          next_cnt = asbi_cnt_t'(`ASBI_WP_CYC);
          next_state = ASBI_WR_PULSE;
        end else begin
          // address setup still running
          next_cnt = cnt - `ASBI_CNT_ONE;
        end
      end
      ASBI_WR_PULSE: begin
        if (cnt == `ASBI_CNT_ONE) begin
          // strobe rise is the first terminating edge: write ends
          next_ws_n = 1'b1;
          next_cnt = asbi_cnt_t'(`ASBI_DH_CYC);
          next_state = ASBI_WR_HOLD;
        end else begin
          // strobe stays low for the whole pulse
          next_cnt = cnt - `ASBI_CNT_ONE;
        end
      end
      ASBI_WR_HOLD: begin
        // data stays driven through the hold time after the strobe rise
        if (cnt == `ASBI_CNT_ONE) begin
          next_dq_oe_n = 1'b1;
          next_cs_l = 1'b1;
          next_cs_h = 1'b0;
          next_ub_n = 1'b1;
          next_lb_n = 1'b1;
          next_busy = 1'b0;
          next_state = ASBI_IDLE;
        end else begin
          // data still held after the strobe rise
          next_cnt = cnt - `ASBI_CNT_ONE;
        end
      end
      default: begin
        // an illegal state code falls back to idle
        next_state = ASBI_IDLE;
      end
    endcase
  end

  // registers of the sequencer and all pin outputs
  // every pin comes straight from one of these flip-flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // sequencer to idle
      state <= ASBI_IDLE;
      cnt <= `ASBI_CNT_RST;
      // user side quiet
      busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= `ASBI_DATA_RST;
      // memory in standby with all strobes off
      mem_addr <= `ASBI_ADDR_RST;
      chip_select_active_low <= 1'b1;
      chip_select_active_high <= 1'b0;
      write_strobe_n <= 1'b1;
      output_drive_enable_n <= 1'b1;
      upper_lane_enable_n <= 1'b1;
      lower_lane_enable_n <= 1'b1;
      // data pins left to the memory
      dq_out <= `ASBI_DATA_RST;
      dq_oe_n <= 1'b1;
    end else begin
      // sequencer
      state <= next_state;
      cnt <= next_cnt;
      // user side
      busy <= next_busy;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      // memory pins
      mem_addr <= next_mem_addr;
      chip_select_active_low <= next_cs_l;
      chip_select_active_high <= next_cs_h;
      write_strobe_n <= next_ws_n;
      output_drive_enable_n <= next_oe_n;
      upper_lane_enable_n <= next_ub_n;
      lower_lane_enable_n <= next_lb_n;
      // data pins
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
    end
  end

endmodule // asbi_host_ctrl

//--- asbi_host_ctrl_properties.sv
`timescale 1ns/100ps
module asbi_chk
  import asbi_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // user side
  input wire logic req,
  input wire logic req_write,
  input wire asbi_addr_t req_addr,
  input wire asbi_data_t req_wdata,
  input wire logic busy,
  input wire logic rd_valid,
  input wire asbi_data_t rd_data,
  // memory pins
  input wire asbi_addr_t mem_addr,
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic write_strobe_n,
  input wire logic output_drive_enable_n,
  input wire asbi_data_t dq_in,
  input wire asbi_data_t dq_out,
  input wire logic dq_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // request taken at this edge
  wire go = req && !busy;
  rd_pins_a: assert property (go && !req_write |=>
    !chip_select_active_low && chip_select_active_high &&
    !output_drive_enable_n && mem_addr == $past(req_addr))
    else $error("read pins wrong");
  // take edge plus five counted cycles, seen one tick later
  rd_time_a: assert property (go && !req_write |->
    ##6 rd_valid && !busy) else $error("read not done on time");
  // pins pass two synchroniser stages and the sampling register
  rd_data_a: assert property (rd_valid |->
    rd_data == $past(dq_in, 3)) else $error("read data not from pins");
  wr_pulse_a: assert property (go && req_write |=> write_strobe_n ##1
    !write_strobe_n && !chip_select_active_low ##1 write_strobe_n)
    else $error("write strobe pulse wrong");
  wr_data_a: assert property (go && req_write |=> !dq_oe_n &&
    dq_out == $past(req_wdata) ##2 !dq_oe_n && $stable(dq_out))
    else $error("write data not held");
  addr_move_a: assert property (!$stable(mem_addr) |-> write_strobe_n)
    else $error("address moved in write");
  no_clash_a: assert property (!dq_oe_n || !write_strobe_n |->
    output_drive_enable_n) else $error("bus contention");
  idle_sel_a: assert property (!busy |-> chip_select_active_low &&
    !chip_select_active_high) else $error("selected while idle");
  c_rd: cover property (go && !req_write);
  c_wr: cover property (go && req_write);
  c_b2b: cover property (rd_valid && go);
endmodule // asbi_chk

bind asbi_host_ctrl asbi_chk u_chk (.core_clk, .srst, .req, .req_write,
  .req_addr, .req_wdata, .busy, .rd_valid, .rd_data, .mem_addr,
  .chip_select_active_low, .chip_select_active_high, .write_strobe_n,
  .output_drive_enable_n, .dq_in, .dq_out, .dq_oe_n);

//--- asbi_sram_mdl.sv
`timescale 1ns/100ps
module asbi_sram_mdl
  import asbi_pkg::*;
#(parameter int ACC_NS = 120)
(
  // memory pins
  input wire asbi_addr_t mem_addr,
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic write_strobe_n,
  input wire logic output_drive_enable_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  // resolved data pins and model drive
  input wire asbi_data_t dq,
  output asbi_data_t q
);
  asbi_data_t mem [0:131071];
  asbi_data_t cur, lane;
  logic [17:0] key, key_late;
  // decode of the mode pins
  wire sel = !chip_select_active_low && chip_select_active_high;
  wire wr = sel && !write_strobe_n;
  wire rd = sel && write_strobe_n && !output_drive_enable_n;
  // data valid only one access time after the last change
  assign key = {mem_addr, rd};
  assign #(ACC_NS) key_late = key;
  assign cur = mem[mem_addr];
  assign lane = {{8{!upper_lane_enable_n}}, {8{!lower_lane_enable_n}}};
  // floating or unsettled bits show the inverse
  assign q = (rd && key_late == key) ? cur ^ ~lane : ~cur;
  // known contents, so lanes never written read back as zero
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = '0;
  end
  // store at the first ending edge
  always @(negedge wr) begin
    if (!upper_lane_enable_n) mem[mem_addr][15:8] <= dq[15:8];
    if (!lower_lane_enable_n) mem[mem_addr][7:0] <= dq[7:0];
  end
endmodule // asbi_sram_mdl

//--- asbi_host_ctrl_tb_top.sv
`timescale 1ns/100ps
module asbi_host_ctrl_tb_top
  import asbi_pkg::*;
;
  logic core_clk = 0, srst = 1, req = 0, req_write = 0;
  logic req_upper = 0, req_lower = 0, busy, rd_valid, dq_oe_n;
  asbi_addr_t req_addr = '0, mem_addr, a;
  asbi_data_t req_wdata = '0, rd_data, dq_in, dq_out, q, d, e;
  logic chip_select_active_low, chip_select_active_high, write_strobe_n;
  logic output_drive_enable_n, upper_lane_enable_n, lower_lane_enable_n;
  int num_errors = 0, samples_checked = 0, cyc = 0, k;
  assign dq_in = dq_oe_n ? q : dq_out;
  always #50 core_clk = ~core_clk;
  asbi_host_ctrl u_asbi_host_ctrl (.core_clk, .srst, .req, .req_write,
    .req_addr, .req_wdata, .req_upper, .req_lower, .busy, .rd_valid,
    .rd_data, .mem_addr, .chip_select_active_low, .chip_select_active_high,
    .write_strobe_n, .output_drive_enable_n, .upper_lane_enable_n,
    .lower_lane_enable_n, .dq_in, .dq_out, .dq_oe_n);
  asbi_sram_mdl u_asbi_sram_mdl (.mem_addr, .chip_select_active_low,
    .chip_select_active_high, .write_strobe_n, .output_drive_enable_n,
    .upper_lane_enable_n, .lower_lane_enable_n, .dq(dq_in), .q);
  function automatic asbi_data_t lmask(logic u, logic l);
    return {{8{u}}, {8{l}}};
  endfunction
  task automatic chk(input string what, input asbi_data_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one access, request held for exactly one edge
  task automatic acc(input logic w, asbi_addr_t ad, asbi_data_t wd,
      input logic u, l);
    req = 1;
    req_write = w;
    req_addr = ad;
    req_wdata = wd;
    req_upper = u;
    req_lower = l;
    @(posedge core_clk);
    #1;
    req = 0;
    while (busy === 1'b1) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic rd(input asbi_addr_t ad, input logic u, l, asbi_data_t x);
    acc(0, ad, 16'h0000, u, l);
    chk("rd_valid", 16'(rd_valid), 16'h0001);
    chk("rd_data", rd_data & lmask(u, l), x & lmask(u, l));
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'hE775));
    repeat (12) @(posedge core_clk);
    #1;
    srst = 0;
    chk("idle pins", 16'({chip_select_active_low, chip_select_active_high,
      write_strobe_n, output_drive_enable_n, dq_oe_n}), 16'h0017);
    // lane merges at both address ends
    for (int i = 0; i < 2; i++) begin
      a = i ? 17'h1FFFF : 17'h00000;
      d = 16'($urandom);
      acc(1, a, d, 1, 1);
      for (k = 1; k < 4; k++) begin
        e = 16'($urandom);
        acc(1, a, e, k[1], k[0]);
        d = (e & lmask(k[1], k[0])) | (d & ~lmask(k[1], k[0]));
        rd(a, 1, 1, d);
      end
    end
    $display("test lanes done");
    // random back-to-back write then read
    repeat (24) begin
      a = 17'($urandom);
      d = 16'($urandom);
      k = 1 + $urandom % 3;
      acc(1, a, d, k[1], k[0]);
      rd(a, k[1], k[0], d);
    end
    $display("test random done");
    conclude();
  end
endmodule // asbi_host_ctrl_tb_top
